// [core/clock_mode_pkg.sv]
/*
  Shared constants and types for the system clock and operating mode
  control block: register offsets, field positions, reset values, mode
  and switch state enumerations.
  Assumes an APB register bus with 8-bit byte addresses, 32-bit data.
*/
package clock_mode_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] main_ctrl_off = 8'h00;
  localparam logic [7:0] aux_ctrl_off  = 8'h04;
  localparam logic [7:0] irq_stat_off  = 8'h08;
  localparam logic [7:0] irq_mask_off  = 8'h0c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int div_lsb    = 5;
  localparam int lto_bit    = 3;
  localparam int hto_bit    = 2;
  localparam int idle_on_halt_enable_bit  = 1;
  localparam int high_low_clock_select_bit  = 0;
  localparam int sysclk_keep_in_idle_bit = 7;
  localparam int d3_bit     = 3;
  localparam int low_voltage_reset_flag_bit   = 2;
  localparam int wrf_bit    = 0;
  localparam int irq_sw     = 0;
  localparam int irq_lvr    = 1;
  localparam int irq_wdt    = 2;

  // ----------------------------------------------------------------
  // reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [2:0] div_reset     = 3'h0;
  localparam logic       idle_on_halt_enable_reset   = 1'b1;
  localparam logic       high_low_clock_select_reset   = 1'b1;
  localparam logic       sysclk_keep_in_idle_reset  = 1'b0;
  localparam logic       d3_reset      = 1'b0;
  localparam logic       low_voltage_reset_flag_reset    = 1'b0;
  localparam logic       wrf_reset     = 1'b0;
  localparam logic [3:0] sel_fast      = 4'h8;
  localparam logic [2:0] switch_sys_n  = 3'h4;
  localparam logic [7:0] fast_settle_n = 8'h10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] div;
    logic       idle_on_halt_enable;
    logic       high_low_clock_select;
  } main_ctrl_t;

  typedef struct packed {
    logic sysclk_keep_in_idle;
    logic d3;
    logic low_voltage_reset_flag;
    logic watchdog_ctrl_reset_flag;
  } aux_ctrl_t;

  typedef enum logic [2:0] {
    full_speed_run, clocked_idle, stopped_idle,
    deep_sleep_no_watchdog, sleep_with_watchdog
  } power_mode_t;

  typedef enum logic [1:0] {
    sw_idle, sw_wait_sys, sw_wait_cur, sw_wait_tar
  } switch_state_t;

endpackage

// [core/system_clock_mode_control.sv]
/*
  System clock source selection and halt mode control, with APB
  registers, oscillator ready flags, reset cause flags and interrupt.
  Assumes oscillator models deliver one-cycle tick pulses on sys_clk
  and that halt, wake and reset events arrive as one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none

module system_clock_mode_control
  import clock_mode_pkg::*;
#(
  parameter logic [7:0] fast_settle = fast_settle_n
)(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // oscillators
  input  wire logic       fast_osc_tick,
  input  wire logic       slow_osc_tick,
  output logic            fast_osc_en,
  output logic            slow_osc_en,
  // cpu and peripherals
  input  wire logic       halt_req,
  input  wire logic       wake_req,
  input  wire logic       watchdog_on,
  output logic            cpu_clk_tick,
  output logic            sys_clk_tick,
  output logic [5:0]      timer_clk_tick,
  // reset causes and interrupt
  input  wire logic       lvr_reset_event,
  input  wire logic       wdt_ctrl_reset_event,
  output logic            irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  main_ctrl_t    ctrl;
  aux_ctrl_t     aux;
  power_mode_t   mode;
  switch_state_t sw_state;
  logic [3:0]    active;
  logic [3:0]    tgt;
  logic [3:0]    req;
  logic [2:0]    sys_cnt;
  logic [7:0]    settle_cnt;
  logic [5:0]    fcnt;
  logic [5:0]    fdiv_tick;
  logic [2:0]    irq_stat;
  logic [2:0]    irq_mask;
  logic          low_osc_ready_flag;
  logic          high_osc_ready_flag;
  logic          sw_done;
  logic          sys_src_tick;
  logic          cur_tick;
  logic          tar_tick;
  logic          wr;
  logic          setup;
  logic          unmapped;
  logic [31:0]   rd_word;

  // slow source for codes 000 and 001
  function automatic logic is_slow(input logic [3:0] s);
    return !s[3] && (s[2:1] == 2'b00);
  endfunction

  function automatic logic src_tick(input logic [3:0] s,
                                    input logic f,
                                    input logic l,
                                    input logic [5:0] d);
    logic [2:0] idx;
    idx = 3'h7 - s[2:0];
    if (s[3])
      return f;
    else if (is_slow(s))
      return l;
    else
      return d[idx];
  endfunction

  // ----------------------------------------------------------------
  // fast clock dividers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      fcnt <= 6'h00;
    else if (fast_osc_tick)
      fcnt <= fcnt + 6'h01;

  genvar k;
  generate
    for (k = 0; k < 6; k++)
    begin : g_div
      assign fdiv_tick[k] = fast_osc_tick && (&fcnt[k:0]);
    end
  endgenerate

  // timer clocks die with the fast oscillator
  assign timer_clk_tick = fast_osc_en ? fdiv_tick : 6'h00;

  // ----------------------------------------------------------------
  // source selection and switching
  // ----------------------------------------------------------------
  assign req = ctrl.high_low_clock_select ? sel_fast : {1'b0, ctrl.div};
  assign sys_src_tick = src_tick(active, fast_osc_tick,
                                 slow_osc_tick, fdiv_tick);
  assign cur_tick = sys_src_tick;
  // the target edge is only trusted once its oscillator is stable
  assign tar_tick = src_tick(tgt, fast_osc_tick, slow_osc_tick,
                             fdiv_tick) && (is_slow(tgt) ? low_osc_ready_flag : high_osc_ready_flag);

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      sw_state <= sw_idle;
      active   <= sel_fast;
      tgt      <= sel_fast;
      sys_cnt  <= 3'h0;
      sw_done  <= 1'b0;
    end
    else
    begin
      sw_done <= 1'b0;
      unique case (sw_state)
        sw_idle:
          if (req != active)
          begin
            tgt      <= req;
            sys_cnt  <= 3'h0;
            sw_state <= sw_wait_sys;
          end
        sw_wait_sys:
          if (sys_cnt == switch_sys_n)
            sw_state <= sw_wait_cur;
          else if (sys_src_tick)
            sys_cnt <= sys_cnt + 3'h1;
        sw_wait_cur:
          if (cur_tick)
            sw_state <= sw_wait_tar;
        sw_wait_tar:
          if (tar_tick)
          begin
            active   <= tgt;
            sw_done  <= 1'b1;
            sw_state <= sw_idle;
          end
      endcase
    end

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      mode <= full_speed_run;
    else
      unique case (mode)
        full_speed_run:
          if (halt_req)
          begin
            if (ctrl.idle_on_halt_enable)
              mode <= aux.sysclk_keep_in_idle ? clocked_idle : stopped_idle;
            else
              mode <= watchdog_on ? sleep_with_watchdog
                                  : deep_sleep_no_watchdog;
          end
        clocked_idle, stopped_idle,
        deep_sleep_no_watchdog, sleep_with_watchdog:
          if (wake_req)
            mode <= full_speed_run;
      endcase

  // fast oscillator runs only while a fast source is used or targeted
  assign fast_osc_en = (mode == full_speed_run || mode == clocked_idle)
                       && (!is_slow(active) ||
                           (sw_state != sw_idle && !is_slow(tgt)));
  assign slow_osc_en = (mode != deep_sleep_no_watchdog);

  assign cpu_clk_tick = sys_src_tick && (mode == full_speed_run);
  assign sys_clk_tick = sys_src_tick && (mode == full_speed_run ||
                                         mode == clocked_idle);

  // ----------------------------------------------------------------
  // oscillator ready flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      low_osc_ready_flag <= 1'b0;
    else if (!slow_osc_en)
      low_osc_ready_flag <= 1'b0;
    else if (slow_osc_tick)
      low_osc_ready_flag <= 1'b1;

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      high_osc_ready_flag        <= 1'b0;
      settle_cnt <= 8'h00;
    end
    else if (!fast_osc_en)
    begin
      high_osc_ready_flag        <= 1'b0;
      settle_cnt <= 8'h00;
    end
    else if (fast_osc_tick && !high_osc_ready_flag)
    begin
      settle_cnt <= settle_cnt + 8'h01;
      if (settle_cnt == fast_settle - 8'h01)
        high_osc_ready_flag <= 1'b1;
    end

  // ----------------------------------------------------------------
  // apb register access
  // ----------------------------------------------------------------
  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && unmapped;

  always_comb
  begin
    rd_word  = 32'h0;
    unmapped = 1'b0;
    case (paddr)
      main_ctrl_off:
      begin
        rd_word[div_lsb +: 3] = ctrl.div;
        rd_word[lto_bit]      = low_osc_ready_flag;
        rd_word[hto_bit]      = high_osc_ready_flag;
        rd_word[idle_on_halt_enable_bit]    = ctrl.idle_on_halt_enable;
        rd_word[high_low_clock_select_bit]    = ctrl.high_low_clock_select;
      end
      aux_ctrl_off:
      begin
        rd_word[sysclk_keep_in_idle_bit] = aux.sysclk_keep_in_idle;
        rd_word[d3_bit]     = aux.d3;
        rd_word[low_voltage_reset_flag_bit]   = aux.low_voltage_reset_flag;
        rd_word[wrf_bit]    = aux.watchdog_ctrl_reset_flag;
      end
      irq_stat_off: rd_word[2:0] = irq_stat;
      irq_mask_off: rd_word[2:0] = irq_mask;
      default:      unmapped = 1'b1;
    endcase
  end

  // read data is captured in the setup cycle so it is a flop output
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      prdata <= 32'h0;
    else if (setup && !pwrite)
      prdata <= rd_word;

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl.div   <= div_reset;
      ctrl.idle_on_halt_enable <= idle_on_halt_enable_reset;
      ctrl.high_low_clock_select <= high_low_clock_select_reset;
    end
    else if (wr && paddr == main_ctrl_off)
    begin
      ctrl.div   <= pwdata[div_lsb +: 3];
      ctrl.idle_on_halt_enable <= pwdata[idle_on_halt_enable_bit];
      ctrl.high_low_clock_select <= pwdata[high_low_clock_select_bit];
    end

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      aux.sysclk_keep_in_idle <= sysclk_keep_in_idle_reset;
      aux.d3     <= d3_reset;
    end
    else if (wr && paddr == aux_ctrl_off)
    begin
      aux.sysclk_keep_in_idle <= pwdata[sysclk_keep_in_idle_bit];
      aux.d3     <= pwdata[d3_bit];
    end

  // reset cause flags: a write of one keeps, zero clears, event wins
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      aux.low_voltage_reset_flag <= low_voltage_reset_flag_reset;
      aux.watchdog_ctrl_reset_flag  <= wrf_reset;
    end
    else
    begin
      if (lvr_reset_event)
        aux.low_voltage_reset_flag <= 1'b1;
      else if (wr && paddr == aux_ctrl_off && !pwdata[low_voltage_reset_flag_bit])
        aux.low_voltage_reset_flag <= 1'b0;
      if (wdt_ctrl_reset_event)
        aux.watchdog_ctrl_reset_flag <= 1'b1;
      else if (wr && paddr == aux_ctrl_off && !pwdata[wrf_bit])
        aux.watchdog_ctrl_reset_flag <= 1'b0;
    end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      irq_stat <= 3'h0;
    else
      irq_stat <= (irq_stat & ~((wr && paddr == irq_stat_off)
                                ? pwdata[2:0] : 3'h0))
                  | {wdt_ctrl_reset_event, lvr_reset_event, sw_done};

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      irq_mask <= 3'h0;
    else if (wr && paddr == irq_mask_off)
      irq_mask <= pwdata[2:0];

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  div_two_sel_a: assert property (active == 4'h7 |->
    sys_src_tick == fdiv_tick[0])
    else $error("divide-by-two source not used");
  fast_sel_a: assert property (active[3] |->
    sys_src_tick == fast_osc_tick)
    else $error("undivided fast source not used");
  fast_off_a: assert property (sw_state == sw_idle && is_slow(active)
    |-> !fast_osc_en)
    else $error("fast oscillator left on in slow run");
  timer_stop_a: assert property (!fast_osc_en |->
    timer_clk_tick == 6'h00)
    else $error("timer tick while fast oscillator off");
  lto_sleep_a: assert property (mode == deep_sleep_no_watchdog |=>
    !low_osc_ready_flag)
    else $error("slow ready set in deep sleep");
  hto_clear_a: assert property (!fast_osc_en |=> !high_osc_ready_flag)
    else $error("fast ready set while oscillator off");
  halt_idle_a: assert property (mode == full_speed_run && halt_req &&
    ctrl.idle_on_halt_enable |=> mode inside {clocked_idle, stopped_idle})
    else $error("halt with idle enable did not idle");
  idle_stop_a: assert property (mode == stopped_idle |->
    !sys_clk_tick && !cpu_clk_tick)
    else $error("clock running in stopped idle");
  unimpl_zero_a: assert property (setup && !pwrite &&
    paddr == aux_ctrl_off |=> prdata[6:4] == 3'h0 &&
    prdata[1] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("unimplemented aux bits not zero");
  low_voltage_reset_flag_set_a: assert property (lvr_reset_event |=> aux.low_voltage_reset_flag)
    else $error("low-voltage flag not set");
  wrf_hold_a: assert property (aux.watchdog_ctrl_reset_flag && !(wr &&
    paddr == aux_ctrl_off && !pwdata[wrf_bit]) |=> aux.watchdog_ctrl_reset_flag)
    else $error("watchdog flag cleared without zero write");
  switch_wait_a: assert property (sw_state == sw_wait_cur |->
    sys_cnt == switch_sys_n)
    else $error("switch skipped system periods");
  run_hold_a: assert property (mode == full_speed_run && !halt_req
    |=> mode == full_speed_run)
    else $error("left run without halt");
  clean_edge_a: assert property ($changed(active) |->
    $past(tar_tick) && $past(sw_state) == sw_wait_tar)
    else $error("source changed off a target edge");

  to_slow_c: cover property (sw_done && is_slow(active));
  to_fast_c: cover property (sw_done && active[3]);
  deep_c:    cover property (mode == deep_sleep_no_watchdog ##1 wake_req);
  irq_c:     cover property ($rose(irq));

endmodule // system_clock_mode_control

`default_nettype wire

// [sim/test_system_clock_mode_control.sv]
/*
  Self-checking bench for the clock source and halt mode control block.
  Assumes clock_mode_pkg and the block from core/; the bench drives every
  input port itself, oscillator ticks included.
*/
`timescale 1ns/10ps
`default_nettype none

module test_system_clock_mode_control;
  import clock_mode_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        fast_osc_tick, slow_osc_tick, fast_osc_en, slow_osc_en;
  logic        halt_req, wake_req, watchdog_on, cpu_clk_tick, sys_clk_tick;
  logic [5:0]  timer_clk_tick;
  logic        lvr_reset_event, wdt_ctrl_reset_event, irq;
  logic [1:0]  fcnt;
  logic [2:0]  scnt;
  int          n_mismatch, compares, cycles, cur_p;

  system_clock_mode_control #(.fast_settle(8'h02)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fast_osc_tick(fast_osc_tick),
    .slow_osc_tick(slow_osc_tick), .fast_osc_en(fast_osc_en),
    .slow_osc_en(slow_osc_en), .halt_req(halt_req), .wake_req(wake_req),
    .watchdog_on(watchdog_on), .cpu_clk_tick(cpu_clk_tick),
    .sys_clk_tick(sys_clk_tick), .timer_clk_tick(timer_clk_tick),
    .lvr_reset_event(lvr_reset_event),
    .wdt_ctrl_reset_event(wdt_ctrl_reset_event), .irq(irq));

  always #20 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // oscillators: fast every 3 cycles, slow every 8, silent when disabled
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    fcnt <= (fcnt == 2'h2) ? 2'h0 : fcnt + 2'h1;
    scnt <= scnt + 3'h1;
    fast_osc_tick <= fast_osc_en && fcnt == 2'h2;
    slow_osc_tick <= slow_osc_en && scnt == 3'h7;
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      $display("[ERR] %0t run timed out", $time);
      n_mismatch++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: halt_req <= 1'b1;
      1: wake_req <= 1'b1;
      2: lvr_reset_event <= 1'b1;
      default: wdt_ctrl_reset_event <= 1'b1;
    endcase
    @(posedge sys_clk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    lvr_reset_event <= 1'b0;
    wdt_ctrl_reset_event <= 1'b0;
  endtask

  // window of 384 cycles holds a whole number of every tick period
  task automatic count(input int e_cpu, input int e_sys, input logic f_on);
    int n_cpu = 0;
    int n_sys = 0;
    int n_tm[6] = '{default: 0};
    repeat (384)
    begin
      @(negedge sys_clk);
      if (cpu_clk_tick === 1'b1) n_cpu++;
      if (sys_clk_tick === 1'b1) n_sys++;
      for (int k = 0; k < 6; k++)
        if (timer_clk_tick[k] === 1'b1) n_tm[k]++;
    end
    chk(n_cpu, e_cpu);
    chk(n_sys, e_sys);
    for (int k = 0; k < 6; k++)
      chk(n_tm[k], f_on ? (128 >> (k + 1)) : 0);
  endtask

  // switch-done interrupt must not come before four current periods
  task automatic wait_switch(input int min_cyc);
    int n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(irq, 1'b1);
    chk(n >= min_cyc, 1'b1);
    apb(1'b1, irq_stat_off, 32'h1);
    rchk(irq_stat_off, 32'h0);
    chk(irq, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk(main_ctrl_off, 32'h0f);
    rchk(aux_ctrl_off, 32'h00);
    rchk(irq_stat_off, 32'h0);
    rchk(irq_mask_off, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, irq_mask_off, 32'h7);
    $display("test reset done");
  endtask

  task automatic t_bits;
    apb(1'b1, aux_ctrl_off, 32'hff);
    rchk(aux_ctrl_off, 32'h88);
    apb(1'b1, main_ctrl_off, 32'hff);
    rchk(main_ctrl_off, 32'hef);
    apb(1'b1, main_ctrl_off, 32'h03);
    apb(1'b1, aux_ctrl_off, 32'h00);
    rchk(aux_ctrl_off, 32'h00);
    $display("test bits done");
  endtask

  task automatic t_flags;
    pulse(2);
    rchk(aux_ctrl_off, 32'h4);
    rchk(irq_stat_off, 32'h2);
    chk(irq, 1'b1);
    apb(1'b1, aux_ctrl_off, 32'h0);
    rchk(aux_ctrl_off, 32'h0);
    pulse(3);
    apb(1'b1, aux_ctrl_off, 32'h1);
    rchk(aux_ctrl_off, 32'h1);
    apb(1'b1, aux_ctrl_off, 32'h0);
    rchk(aux_ctrl_off, 32'h0);
    apb(1'b1, irq_stat_off, 32'h6);
    rchk(irq_stat_off, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, irq_mask_off, 32'h1);
    pulse(2);
    rchk(irq_stat_off, 32'h2);
    chk(irq, 1'b0);
    apb(1'b1, irq_stat_off, 32'h2);
    apb(1'b1, aux_ctrl_off, 32'h0);
    apb(1'b1, irq_mask_off, 32'h7);
    $display("test flags done");
  endtask

  task automatic t_speeds;
    count(128, 128, 1'b1);
    for (int c = 7; c >= 2; c--)
    begin
      apb(1'b1, main_ctrl_off, 32'(c << 5) | 32'h2);
      wait_switch(4 * cur_p);
      cur_p = 3 << (8 - c);
      count(128 >> (8 - c), 128 >> (8 - c), 1'b1);
    end
    $display("test speeds done");
  endtask

  task automatic t_slow;
    apb(1'b1, main_ctrl_off, 32'h02);
    wait_switch(4 * cur_p);
    cur_p = 8;
    chk(fast_osc_en, 1'b0);
    rchk(main_ctrl_off, 32'h0a);
    count(48, 48, 1'b0);
    apb(1'b1, main_ctrl_off, 32'h22);
    wait_switch(4 * cur_p);
    count(48, 48, 1'b0);
    apb(1'b1, main_ctrl_off, 32'h03);
    wait_switch(4 * cur_p);
    cur_p = 3;
    rchk(main_ctrl_off, 32'h0f);
    count(128, 128, 1'b1);
    $display("test slow done");
  endtask

  // i: 0 clocked idle, 1 stopped idle, 2 sleep with watchdog, 3 deep sleep
  task automatic t_halt;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, aux_ctrl_off, (i == 0) ? 32'h80 : 32'h0);
      apb(1'b1, main_ctrl_off, (i < 2) ? 32'h03 : 32'h01);
      watchdog_on <= (i == 2);
      pulse(0);
      repeat (8) @(posedge sys_clk);
      count(0, (i == 0) ? 128 : 0, i == 0);
      chk(slow_osc_en, i != 3);
      apb(1'b0, main_ctrl_off, 32'h0);
      chk(rd[lto_bit], i != 3);
      pulse(1);
      repeat (20) @(posedge sys_clk);
      rchk(main_ctrl_off, (i < 2) ? 32'h0f : 32'h0d);
      count(128, 128, 1'b1);
    end
    apb(1'b1, main_ctrl_off, 32'h03);
    $display("test halt done");
  endtask

  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fast_osc_tick, slow_osc_tick, halt_req, wake_req, watchdog_on} = '0;
    {lvr_reset_event, wdt_ctrl_reset_event, fcnt, scnt} = '0;
    {n_mismatch, compares, cycles} = '0;
    cur_p = 3;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge sys_clk);
    t_reset();
    t_bits();
    t_flags();
    t_speeds();
    t_slow();
    t_halt();
    end_of_test();
  end

endmodule // test_system_clock_mode_control

`default_nettype wire
